// ---- design/pcm_cfg.svh ----
/*
 * Constants of the control-pin and management block: register offsets,
 * field positions, reset values, frame lengths and timing counts.
 * Assumes a 25 MHz system clock and a clause 22 management frame.
 */
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// Register offsets (5-bit management register address)
`define PCM_REG_INT_TEST 5'h11
`define PCM_REG_INTERRUPT_STATUS_THREE 5'h18

// Interrupt test control: bit that makes the interrupt pin active high
`define PCM_POL_BIT 3
`define PCM_TEST_RST 16'h0000
`define PCM_TEST_WMASK 16'h0008

// Interrupt status three: enables in [1:0], sticky flags in [9:8]
`define PCM_EN_LO 0
`define PCM_STAT_LO 8
`define PCM_EV_POR 0
`define PCM_EV_WAKE 1
`define PCM_EN_RST 2'h1
`define PCM_STAT_RST 2'h0

// Management frame
`define PCM_PRE_LEN 6'h20
`define PCM_HDR_LAST 4'hB
`define PCM_DATA_LAST 4'hF
`define PCM_TA_LAST 4'h1
`define PCM_OP_RD 2'h2
`define PCM_OP_WR 2'h1

// Timing: clock period and least reset pulse, both in ns
`define PCM_CLK_NS 40
`define PCM_RST_MIN_NS 1000
`define PCM_RST_MIN_CYC ((`PCM_RST_MIN_NS + `PCM_CLK_NS - 1) / `PCM_CLK_NS)

// Synchroniser width: mdc, mdio, reset pin, enable, wake, five straps
`define PCM_SYNC_W 10

`endif

// ---- design/pcm_pkg.sv ----
/*
 * Types of the control-pin and management block.
 * Assumes nothing of its surroundings.
 */
package pcm_pkg;

   // Operating state of the device as seen at the control pins
   typedef enum logic [1:0] {
      PS_RESET = 2'b00,
      PS_ACTIVE = 2'b01,
      PS_SLEEP = 2'b10,
      PS_DISABLED = 2'b11
   } pcm_pwr_t;

   // Position within a management frame
   typedef enum logic [2:0] {
      MS_PRE = 3'b000,
      MS_START = 3'b001,
      MS_HDR = 3'b010,
      MS_TA = 3'b011,
      MS_DATA = 3'b100
   } pcm_mgmt_t;

endpackage : pcm_pkg

// ---- design/pcm_sync.sv ----
/*
 * Two-stage synchroniser for a vector of independent levels.
 * Assumes each bit is a level from outside the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pcm_sync #(
   parameter int W = 1
) (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] stage1; // Read only by stage two
   logic [W-1:0] stage2; // Safe copy
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_stage2;

   // Next values, frozen while the enable is low
   always_comb begin
      next_stage1 = ce_i ? async_i : stage1;
      next_stage2 = ce_i ? stage1 : stage2;
   end

   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   assign sync_o = stage2;

endmodule : pcm_sync

`default_nettype wire

// ---- design/pcm_top.sv ----
/*
 * Control pins and serial management port of a single-pair Ethernet
 * transceiver: reset, enable, wake, inhibit, interrupt and a clause 22
 * management slave holding the interrupt registers.
 * Assumes all pins are asynchronous to clk_sys_i and that the management
 * clock is well below the system clock (sampled by edge detection).
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcm_cfg.svh"

module pcm_top (
   // Clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Management port pins
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_out_o,
   output logic mdio_oe_o,
   // Control pins
   input wire logic reset_pin_n_i,
   input wire logic enable_i,
   input wire logic wake_i,
   input wire logic [4:0] strap_i,
   output logic inhibit_out_o,
   output logic int_out_o,
   output logic int_oe_o,
   // Internal side
   input wire logic sleep_req_i,
   output logic blocks_on_o,
   output logic [4:0] strap_o
);

   localparam logic [4:0] RST_LAST = 5'(`PCM_RST_MIN_CYC - 1);

   // Synchronised pins
   logic [`PCM_SYNC_W-1:0] pins_s;
   logic s_mdc, s_mdio, s_rstn, s_en, s_wake;
   logic [4:0] s_strap;

   // Pins cross through two flops; the clocks are unrelated
   pcm_sync #(.W(`PCM_SYNC_W)) u_sync (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .async_i({strap_i, wake_i, enable_i, reset_pin_n_i, mdio_i, mdc_i}),
      .sync_o(pins_s)
   );
   assign {s_strap, s_wake, s_en, s_rstn, s_mdio, s_mdc} = pins_s;

   // Power state group
   pcm_pkg::pcm_pwr_t pwr, next_pwr; // Operating state
   logic [4:0] low_cnt, next_low_cnt; // Cycles the reset pin has been low
   logic wake_hold, next_wake_hold; // Wake high since reset release, cleared when wake falls
   logic [4:0] strap, next_strap; // Captured straps (PHY address)
   logic por_set, wake_set; // One-cycle events
   logic pin_rst; // Reset pin held long enough

   // Power sequencing
   always_comb begin
      next_pwr = pwr;
      next_low_cnt = low_cnt;
      next_wake_hold = wake_hold & s_wake;
      next_strap = strap;
      por_set = 1'b0;
      wake_set = 1'b0;
      pin_rst = !s_rstn && (low_cnt == RST_LAST);
      // Count low cycles; short glitches never reset the device
      if (s_rstn) begin
         next_low_cnt = 5'h00;
      end else if (low_cnt != RST_LAST) begin
         next_low_cnt = low_cnt + 5'h01;
      end
      if (pin_rst) begin
         next_pwr = pcm_pkg::PS_RESET;
      end else begin
         case (pwr)
            pcm_pkg::PS_RESET: begin
               // Leave reset once the pin is high; resample straps
               if (s_rstn) begin
                  next_strap = s_strap;
                  next_wake_hold = s_wake;
                  por_set = 1'b1;
                  next_pwr = s_en ? pcm_pkg::PS_ACTIVE : pcm_pkg::PS_DISABLED;
               end
            end
            pcm_pkg::PS_ACTIVE: begin
               if (!s_en) begin
                  next_pwr = pcm_pkg::PS_DISABLED;
               end else if (sleep_req_i && !s_wake && !wake_hold) begin
                  next_pwr = pcm_pkg::PS_SLEEP;
               end
            end
            pcm_pkg::PS_SLEEP: begin
               if (!s_en) begin
                  next_pwr = pcm_pkg::PS_DISABLED;
               end else if (s_wake) begin
                  next_pwr = pcm_pkg::PS_ACTIVE;
                  wake_set = 1'b1;
               end
            end
            pcm_pkg::PS_DISABLED: begin
               // Blocks stay off and inhibit stays high until enable returns
               if (s_en) begin
                  next_pwr = pcm_pkg::PS_ACTIVE;
               end
            end
            default: begin
               next_pwr = pcm_pkg::PS_RESET;
            end
         endcase
      end
   end

   // Power state registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pwr <= pcm_pkg::PS_RESET;
         low_cnt <= 5'h00;
         wake_hold <= 1'b0;
         strap <= 5'h00;
      end else if (ce_i) begin
         pwr <= next_pwr;
         low_cnt <= next_low_cnt;
         wake_hold <= next_wake_hold;
         strap <= next_strap;
      end
   end

   // Inhibit and block power follow the state directly
   assign inhibit_out_o = (pwr == pcm_pkg::PS_SLEEP) || (pwr == pcm_pkg::PS_DISABLED);
   assign blocks_on_o = (pwr == pcm_pkg::PS_ACTIVE);
   assign strap_o = strap;

   // Register decode: bit 0 test control, bit 1 status three
   function automatic logic [1:0] pcm_dec(input logic [4:0] addr);
      pcm_dec = {addr == `PCM_REG_INTERRUPT_STATUS_THREE, addr == `PCM_REG_INT_TEST};
   endfunction : pcm_dec

   // Management frame group
   pcm_pkg::pcm_mgmt_t ms, next_ms; // Frame position
   logic mdc_d, next_mdc_d; // Previous synchronised clock
   logic [5:0] pre_cnt, next_pre_cnt; // Ones seen in preamble
   logic [3:0] bit_cnt, next_bit_cnt; // Bit within field
   logic [15:0] shreg, next_shreg; // Header, write or read data
   logic [4:0] raddr, next_raddr; // Addressed register
   logic is_rd, next_is_rd; // Read addressed to us
   logic is_wr, next_is_wr; // Write addressed to us
   logic oe, next_oe; // Read drive window; zero bits pull the line low
   logic mdc_rise; // Sampling edge
   logic [11:0] hdr; // Header including current bit
   logic wr_stb; // Register write, one cycle
   logic rd_take; // Read data latched, one cycle
   logic [15:0] wr_data;
   logic [15:0] test_reg, next_test_reg; // Interrupt test control
   logic [1:0] int_en, next_int_en; // Trigger enables
   logic [1:0] int_stat, next_int_stat; // Sticky flags
   logic int_out, next_int_out; // Registered pin level
   logic int_oe, next_int_oe; // Registered pin drive
   logic irq; // Enabled flag pending
   logic [1:0] ev; // Trigger events this cycle
   logic [1:0] clr; // Flags cleared by a read
   logic [1:0] sel; // Decoded register
   logic [15:0] rd_data; // Value of the addressed register

   // Frame receive and transmit, stepped on each rising clock
   always_comb begin
      next_ms = ms;
      next_mdc_d = s_mdc;
      next_pre_cnt = pre_cnt;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_raddr = raddr;
      next_is_rd = is_rd;
      next_is_wr = is_wr;
      next_oe = oe;
      wr_stb = 1'b0;
      rd_take = 1'b0;
      wr_data = {shreg[14:0], s_mdio};
      hdr = {shreg[10:0], s_mdio};
      // Rate independent: only edges count, no timeout
      mdc_rise = s_mdc && !mdc_d;
      if (mdc_rise) begin
         case (ms)
            pcm_pkg::MS_PRE: begin
               // Count ones; a zero after a full preamble starts a frame
               if (s_mdio) begin
                  if (pre_cnt != `PCM_PRE_LEN) begin
                     next_pre_cnt = pre_cnt + 6'h01;
                  end
               end else begin
                  next_pre_cnt = 6'h00;
                  if (pre_cnt == `PCM_PRE_LEN) begin
                     next_ms = pcm_pkg::MS_START;
                  end
               end
            end
            pcm_pkg::MS_START: begin
               // Second start bit must be one, else hunt again
               next_bit_cnt = 4'h0;
               next_ms = s_mdio ? pcm_pkg::MS_HDR : pcm_pkg::MS_PRE;
            end
            pcm_pkg::MS_HDR: begin
               next_shreg = {shreg[14:0], s_mdio};
               if (bit_cnt == `PCM_HDR_LAST) begin
                  // Only frames for the captured strap address are answered
                  next_raddr = hdr[4:0];
                  next_is_rd = (hdr[11:10] == `PCM_OP_RD) && (hdr[9:5] == strap);
                  next_is_wr = (hdr[11:10] == `PCM_OP_WR) && (hdr[9:5] == strap);
                  next_bit_cnt = 4'h0;
                  next_ms = pcm_pkg::MS_TA;
               end else begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            pcm_pkg::MS_TA: begin
               if (bit_cnt != `PCM_TA_LAST) begin
                  // Reads pull the second turnaround bit low
                  next_bit_cnt = `PCM_TA_LAST;
                  next_oe = is_rd;
                  next_shreg = 16'h0000;
               end else begin
                  // Data is taken once here, so a clearing read acts once
                  next_bit_cnt = 4'h0;
                  next_ms = pcm_pkg::MS_DATA;
                  if (is_rd) begin
                     next_shreg = rd_data;
                     rd_take = 1'b1;
                  end
               end
            end
            pcm_pkg::MS_DATA: begin
               // Reads shift ones in behind the data so the line releases
               next_shreg = is_rd ? {shreg[14:0], 1'b1} : wr_data;
               if (bit_cnt == `PCM_DATA_LAST) begin
                  wr_stb = is_wr;
                  next_oe = 1'b0;
                  next_is_rd = 1'b0;
                  next_is_wr = 1'b0;
                  next_pre_cnt = 6'h00;
                  next_ms = pcm_pkg::MS_PRE;
               end else begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
            end
            default: begin
               next_ms = pcm_pkg::MS_PRE;
            end
         endcase
      end
      // A pin reset abandons any frame and releases the line
      if (pin_rst) begin
         next_ms = pcm_pkg::MS_PRE;
         next_pre_cnt = 6'h00;
         next_oe = 1'b0;
         next_is_rd = 1'b0;
         next_is_wr = 1'b0;
      end
   end

   // Frame registers; all of them, data flops included, are reset by srst_i
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ms <= pcm_pkg::MS_PRE;
         mdc_d <= 1'b0;
         pre_cnt <= 6'h00;
         bit_cnt <= 4'h0;
         shreg <= 16'hFFFF;
         raddr <= 5'h00;
         is_rd <= 1'b0;
         is_wr <= 1'b0;
         oe <= 1'b0;
      end else if (ce_i) begin
         ms <= next_ms;
         mdc_d <= next_mdc_d;
         pre_cnt <= next_pre_cnt;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         raddr <= next_raddr;
         is_rd <= next_is_rd;
         is_wr <= next_is_wr;
         oe <= next_oe;
      end
   end

   // Only low levels are driven; ones are left to the pull-up
   assign mdio_out_o = shreg[15];
   assign mdio_oe_o = oe && !shreg[15];

   // Read data of the addressed register
   assign sel = pcm_dec(raddr);
   always_comb begin
      rd_data = 16'h0000;
      if (sel[0]) begin
         rd_data = test_reg;
      end
      if (sel[1]) begin
         rd_data[`PCM_EN_LO +: 2] = int_en;
         rd_data[`PCM_STAT_LO +: 2] = int_stat;
      end
   end

   // Interrupt registers, sticky flags and pin drive
   always_comb begin
      next_test_reg = test_reg;
      next_int_en = int_en;
      irq = |(int_stat & int_en);
      ev = 2'h0;
      ev[`PCM_EV_POR] = por_set;
      ev[`PCM_EV_WAKE] = wake_set;
      // Reading status three clears its flags
      clr = (rd_take && sel[1]) ? 2'h3 : 2'h0;
      // Only enabled triggers flag; a set beats a clear
      next_int_stat = (int_stat & ~clr) | (ev & int_en);
      if (wr_stb && sel[0]) begin
         next_test_reg = wr_data & `PCM_TEST_WMASK;
      end
      if (wr_stb && sel[1]) begin
         next_int_en = wr_data[`PCM_EN_LO +: 2];
      end
      // Active low pulls only while an enabled flag is pending; active high drives both levels
      next_int_out = test_reg[`PCM_POL_BIT] & irq;
      next_int_oe = test_reg[`PCM_POL_BIT] | irq;
      // Pin reset restores defaults; power-on trigger stays on
      if (pin_rst) begin
         next_test_reg = `PCM_TEST_RST;
         next_int_en = `PCM_EN_RST;
         next_int_stat = `PCM_STAT_RST;
         next_int_out = 1'b0;
         next_int_oe = 1'b0;
      end
   end

   // Interrupt register flops
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         test_reg <= `PCM_TEST_RST;
         int_en <= `PCM_EN_RST;
         int_stat <= `PCM_STAT_RST;
         int_out <= 1'b0;
         int_oe <= 1'b0;
      end else if (ce_i) begin
         test_reg <= next_test_reg;
         int_en <= next_int_en;
         int_stat <= next_int_stat;
         int_out <= next_int_out;
         int_oe <= next_int_oe;
      end
   end

   assign int_out_o = int_out;
   assign int_oe_o = int_oe;

   // Assertions on what the block drives
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   // Steps of a read turnaround and of a frame end
   sequence s_ta_first;
      ce_i && mdc_rise && !pin_rst && (ms == pcm_pkg::MS_TA) && (bit_cnt == 4'h0) && is_rd;
   endsequence
   sequence s_line_low;
      mdio_oe_o && !mdio_out_o;
   endsequence
   sequence s_last_bit;
      ce_i && mdc_rise && !pin_rst && (ms == pcm_pkg::MS_DATA) && (bit_cnt == `PCM_DATA_LAST);
   endsequence
   // Interrupt conditions
   sequence s_irq_low;
      ce_i && !pin_rst && irq && !test_reg[`PCM_POL_BIT];
   endsequence
   sequence s_flag_held;
      ce_i && !pin_rst && int_stat[`PCM_EV_POR] && !clr[`PCM_EV_POR];
   endsequence
   sequence s_clear_read;
      ce_i && !pin_rst && clr[`PCM_EV_POR] && !por_set;
   endsequence

   a_ta_drive: assert property (s_ta_first |=> s_line_low)
      else $error("Read turnaround not driven low");
   a_frame_release: assert property (s_last_bit |=> !mdio_oe_o)
      else $error("Data line not released after frame");
   a_pin_reset: assert property ((ce_i && pin_rst) |=> (pwr == pcm_pkg::PS_RESET))
      else $error("Pin reset did not reset the state");
   a_regs_default: assert property ((ce_i && pin_rst) |=> (int_en == `PCM_EN_RST))
      else $error("Enables not at default after pin reset");
   a_int_low: assert property (s_irq_low |=> (int_oe_o && !int_out_o))
      else $error("Interrupt pin not pulled low");
   a_flag_sticky: assert property (s_flag_held |=> int_stat[`PCM_EV_POR])
      else $error("Event flag cleared on its own");
   a_read_clear: assert property (s_clear_read |=> !int_stat[`PCM_EV_POR])
      else $error("Status read did not clear flag");

endmodule : pcm_top

`default_nettype wire

// ---- tb/pcm_host_model.sv ----
/*
 * Host management station: clocks clause 22 frames at 320 ns.
 * Assumes the bench pulls the data line up and merges all drivers.
 */
`timescale 1ns/1ps
`default_nettype none

module pcm_host_model (
   // Management pins
   output logic mdc_o,
   output logic md_low_o,
   input wire logic mdio_i
);
   // Clock stands low between frames
   initial begin
      mdc_o = 1'b0;
      md_low_o = 1'b0;
   end

   // Whole frame; line released on ones and read data
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] v;
      v = {32'hFFFF_FFFF, 2'b01, op, pa, ra, op[1] ? 2'b11 : 2'b10, wd};
      // Offset keeps link edges off the system clock edges
      #7;
      for (int i = 63; i >= 0; i--) begin
         md_low_o = ~v[i];
         #160;
         mdc_o = 1'b1;
         if (i < 16) rd[i] = mdio_i;
         #160;
         mdc_o = 1'b0;
      end
      md_low_o = 1'b0;
   endtask : frame
endmodule : pcm_host_model

`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 * Bench of the control-pin block: pins, sleep, enable and registers.
 * Assumes the management address follows the strap pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pcm_cfg.svh"

module tb_top;
   logic clk_sys_i;
   logic srst_i;
   logic reset_pin_n_i;
   logic enable_i;
   logic wake_i;
   logic sleep_req_i;
   logic [4:0] strap_i;
   logic mdc, md_low, mdio_out, mdio_oe;
   logic inhibit_out, int_out, int_oe, blocks_on;
   logic [4:0] strap_o;
   int n_mismatch = 0;
   int compares = 0;
   // Pulled-up wires, low when any party pulls
   wire mdio_w = ~(md_low | (mdio_oe & ~mdio_out));
   wire int_pin = ~(int_oe & ~int_out);

   pcm_top DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
      .mdc_i(mdc), .mdio_i(mdio_w), .mdio_out_o(mdio_out), .mdio_oe_o(mdio_oe),
      .reset_pin_n_i(reset_pin_n_i), .enable_i(enable_i), .wake_i(wake_i),
      .strap_i(strap_i), .inhibit_out_o(inhibit_out), .int_out_o(int_out),
      .int_oe_o(int_oe), .sleep_req_i(sleep_req_i), .blocks_on_o(blocks_on),
      .strap_o(strap_o));

   pcm_host_model u_host (.mdc_o(mdc), .md_low_o(md_low), .mdio_i(mdio_w));

   // 25 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : wait_cyc

   task automatic reg_rd(input logic [4:0] ra, input logic [15:0] exp);
      logic [15:0] d;
      u_host.frame(`PCM_OP_RD, strap_i, ra, 16'hFFFF, d);
      check(d, exp);
      wait_cyc(4);
   endtask : reg_rd

   task automatic reg_wr(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] d;
      u_host.frame(`PCM_OP_WR, strap_i, ra, wd, d);
      wait_cyc(4);
   endtask : reg_wr

   task automatic wrap_up;
      $display("Mismatches %0d, compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Watchdog, well past the roughly 3900 cycles of the run
   initial begin
      wait_cyc(20000);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      srst_i = 1'b1;
      reset_pin_n_i = 1'b1;
      enable_i = 1'b1;
      wake_i = 1'b0;
      sleep_req_i = 1'b0;
      strap_i = 5'h01;
      wait_cyc(6);
      srst_i <= 1'b0;
      wait_cyc(60);
      check(16'(strap_o), 16'h0001);
      check(16'(inhibit_out), 16'h0000);
      check(16'(int_pin), 16'h0000);
      reg_rd(`PCM_REG_INTERRUPT_STATUS_THREE, 16'h0101);
      check(16'(int_pin), 16'h0001);
      reg_rd(`PCM_REG_INTERRUPT_STATUS_THREE, 16'h0001);
      reg_wr(`PCM_REG_INT_TEST, 16'hFFFF);
      reg_rd(`PCM_REG_INT_TEST, 16'h0008);
      check(16'(int_pin), 16'h0000);
      // Pin reset just past its least width, new straps
      reset_pin_n_i <= 1'b0;
      strap_i <= 5'h06;
      wait_cyc(`PCM_RST_MIN_CYC + 2);
      reset_pin_n_i <= 1'b1;
      wait_cyc(60);
      check(16'(strap_o), 16'h0006);
      check(16'(int_pin), 16'h0000);
      reg_rd(`PCM_REG_INT_TEST, 16'h0000);
      reg_rd(`PCM_REG_INTERRUPT_STATUS_THREE, 16'h0101);
      reg_wr(`PCM_REG_INTERRUPT_STATUS_THREE, 16'h0000);
      // Sleep, then wake with every trigger off
      sleep_req_i <= 1'b1;
      wait_cyc(20);
      check(16'(inhibit_out), 16'h0001);
      wake_i <= 1'b1;
      wait_cyc(20);
      check(16'(inhibit_out), 16'h0000);
      check(16'(int_pin), 16'h0001);
      enable_i <= 1'b0;
      wait_cyc(20);
      check(16'(inhibit_out), 16'h0001);
      check(16'(blocks_on), 16'h0000);
      enable_i <= 1'b1;
      wait_cyc(20);
      check(16'(blocks_on), 16'h0001);
      // Power-up with wake high and sleep asked for
      srst_i <= 1'b1;
      wait_cyc(6);
      srst_i <= 1'b0;
      wait_cyc(60);
      check(16'(inhibit_out), 16'h0000);
      wrap_up();
   end
endmodule : tb_top

`default_nettype wire
